// [core/lsa_pkg.sv]
// Function
// - register offset address is base plus shifted offset
// - byte, halfword, word sizes, signed or unsigned
// - reject illegal registers in register offset form
// - word load to pc branches, bit zero cleared
// - conditional pc load only last in block
// - these instructions never change condition flags
// - unprivileged offset zero to 255 added
// - unprivileged form always issues unprivileged access
// - unprivileged form rejects pc base, sp/pc transfer
// - zero-extend unsigned, sign-extend signed loads
// - pc-relative offset limits 4095 and 1020
// - two-word load rejects bad second destination
// - increment-after ascends from base, low register first
// - decrement-before descends below base, high register first
// - increment-after writeback is base plus 4(n-1)
// - decrement-before writeback is base minus 4n
// - multiple transfer rejects illegal base and lists
// - list non-empty, every register moved as word
// - alias forms decode to the right order
// - plain offset keeps base register unchanged
`default_nettype none

package lsa_pkg;

  // ----------------------------------------------------------------
  // constants
  // ----------------------------------------------------------------
  localparam logic [3:0] LSA_REG_SP = 4'hD;
  localparam logic [3:0] LSA_REG_LR = 4'hE;
  localparam logic [3:0] LSA_REG_PC = 4'hF;
  localparam logic [1:0] LSA_SHIFT_MAX = 2'h3;
  localparam logic [7:0] LSA_UNPRIV_OFS_MAX = 8'hFF;
  localparam logic [12:0] LSA_PCREL_SINGLE_MAX = 13'h0FFF;
  localparam logic [12:0] LSA_PCREL_DUAL_MAX = 13'h03FC;
  localparam logic [31:0] LSA_WORD_STEP = 32'h0000_0004;
  localparam logic [31:0] LSA_PC_BIT0_CLEAR = 32'hFFFF_FFFE;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    LSA_OP_REG_OFS,
    LSA_OP_UNPRIV,
    LSA_OP_PCREL,
    LSA_OP_PCREL_DUAL,
    LSA_OP_MULTI
  } lsa_form_t;

  typedef enum logic [1:0] {
    LSA_SZ_BYTE,
    LSA_SZ_HALF,
    LSA_SZ_WORD
  } lsa_size_t;

  typedef enum logic [2:0] {
    LSA_AM_INC_AFTER,
    LSA_AM_DEC_BEFORE,
    LSA_AM_FD_POP,
    LSA_AM_EA_PUSH,
    LSA_AM_EA_POP,
    LSA_AM_FD_PUSH
  } lsa_amode_t;

  typedef struct packed {
    lsa_form_t form;
    logic is_load;
    lsa_size_t size;
    logic signed_ld;
    logic [3:0] base_reg;
    logic [3:0] offset_reg;
    logic [3:0] transfer_reg;
    logic [3:0] second_transfer_reg;
    logic [1:0] shift;
    logic [7:0] unpriv_ofs;
    logic [12:0] pcrel_ofs;
    logic pcrel_neg;
    lsa_amode_t amode;
    logic writeback;
    logic [15:0] reg_list;
    logic cond;
    logic last_in_block;
    logic privileged;
  } lsa_instr_t;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic write;
    lsa_size_t size;
    logic unpriv;
    logic [31:0] wdata;
  } lsa_mem_req_t;

  typedef struct packed {
    logic valid;
    logic [3:0] reg_idx;
    logic [31:0] value;
  } lsa_reg_wr_t;

endpackage : lsa_pkg

`default_nettype wire

// [core/lsa_check.sv]
`default_nettype none

// operand legality, purely combinational
module lsa_check (
  input wire lsa_pkg::lsa_instr_t instr,
  output logic illegal
);

  function automatic logic is_sp_or_pc(input logic [3:0] r);
    return (r == lsa_pkg::LSA_REG_SP) || (r == lsa_pkg::LSA_REG_PC);
  endfunction : is_sp_or_pc

  logic pc_tr;
  logic word_ld;

  always_comb begin
    illegal = 1'b0;
    pc_tr = instr.transfer_reg == lsa_pkg::LSA_REG_PC;
    word_ld = instr.is_load && instr.size == lsa_pkg::LSA_SZ_WORD;
    case (instr.form)
      lsa_pkg::LSA_OP_REG_OFS: begin
        illegal = (instr.base_reg == lsa_pkg::LSA_REG_PC) || is_sp_or_pc(instr.offset_reg) ||
                  (instr.transfer_reg == lsa_pkg::LSA_REG_SP &&
                   instr.size != lsa_pkg::LSA_SZ_WORD) ||
                  (pc_tr && !word_ld);
        if (instr.signed_ld && !instr.is_load) begin
          illegal = 1'b1;
        end
      end
      lsa_pkg::LSA_OP_UNPRIV: begin
        illegal = (instr.base_reg == lsa_pkg::LSA_REG_PC) ||
                  is_sp_or_pc(instr.transfer_reg) ||
                  (instr.signed_ld && !instr.is_load);
      end
      lsa_pkg::LSA_OP_PCREL: begin
        illegal = !instr.is_load || (instr.pcrel_ofs > lsa_pkg::LSA_PCREL_SINGLE_MAX) ||
                  (is_sp_or_pc(instr.transfer_reg) && !word_ld);
      end
      lsa_pkg::LSA_OP_PCREL_DUAL: begin
        illegal = !instr.is_load || (instr.pcrel_ofs > lsa_pkg::LSA_PCREL_DUAL_MAX) ||
                  (instr.pcrel_ofs[1:0] != 2'h0) ||
                  is_sp_or_pc(instr.second_transfer_reg) ||
                  (instr.transfer_reg == instr.second_transfer_reg) ||
                  is_sp_or_pc(instr.transfer_reg);
      end
      lsa_pkg::LSA_OP_MULTI: begin
        illegal = (instr.base_reg == lsa_pkg::LSA_REG_PC) ||
                  instr.reg_list[lsa_pkg::LSA_REG_SP] ||
                  (!instr.is_load && instr.reg_list[lsa_pkg::LSA_REG_PC]) ||
                  (instr.is_load && instr.reg_list[lsa_pkg::LSA_REG_PC] &&
                   instr.reg_list[lsa_pkg::LSA_REG_LR]) ||
                  (instr.writeback && instr.reg_list[instr.base_reg]);
        if (instr.reg_list == 16'h0000) begin
          illegal = 1'b1;
        end
      end
      default: illegal = 1'b1;
    endcase
    // a pc load that is conditional must close its if-then block
    if (instr.is_load && instr.cond && !instr.last_in_block &&
        ((instr.form != lsa_pkg::LSA_OP_MULTI && pc_tr && word_ld) ||
         (instr.form == lsa_pkg::LSA_OP_MULTI && instr.reg_list[lsa_pkg::LSA_REG_PC]))) begin
      illegal = 1'b1;
    end
  end

endmodule : lsa_check

`default_nettype wire

// [core/lsa_unit.sv]
`default_nettype none

module lsa_unit (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic instr_valid,
  output logic instr_ready,
  input wire lsa_pkg::lsa_instr_t instr,
  input wire logic [31:0] base_val,
  input wire logic [31:0] offset_val,
  input wire logic [31:0] pc_val,
  output logic [3:0] rd_idx,
  input wire logic [31:0] rd_val,
  output lsa_pkg::lsa_mem_req_t mem_req,
  input wire logic mem_ready,
  input wire logic mem_rvalid,
  input wire logic [31:0] mem_rdata,
  output lsa_pkg::lsa_reg_wr_t reg_wr,
  output logic branch_valid,
  output logic [31:0] branch_target,
  output logic flags_we,
  output logic unpredictable,
  output logic done
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LSA_ST_IDLE,
    LSA_ST_REQ,
    LSA_ST_WAIT,
    LSA_ST_WB
  } lsa_state_t;

  typedef struct packed {
    lsa_state_t st;
    lsa_pkg::lsa_instr_t ins;
    logic [31:0] addr;
    logic [31:0] base;
    logic [15:0] left;
    logic [3:0] cur;
    logic [4:0] count;
    logic second;
    lsa_pkg::lsa_mem_req_t req;
    lsa_pkg::lsa_reg_wr_t wr;
    logic br_v;
    logic [31:0] br_t;
    logic unpred;
    logic done;
  } lsa_state_all_t;

  lsa_state_all_t s_q;
  lsa_state_all_t s_d;
  logic illegal;

  lsa_check u_check (
    .instr(instr),
    .illegal(illegal)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [4:0] pop_count(input logic [15:0] l);
    logic [4:0] n;
    n = 5'h00;
    for (int i = 0; i < 16; i++) begin
      n = n + {4'h0, l[i]};
    end
    return n;
  endfunction : pop_count

  function automatic logic [3:0] low_reg(input logic [15:0] l);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (l[i]) begin
        r = i[3:0];
      end
    end
    return r;
  endfunction : low_reg

  function automatic logic [3:0] high_reg(input logic [15:0] l);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (l[i]) begin
        r = i[3:0];
      end
    end
    return r;
  endfunction : high_reg

  function automatic logic is_dec(input lsa_pkg::lsa_amode_t m);
    return (m == lsa_pkg::LSA_AM_DEC_BEFORE) || (m == lsa_pkg::LSA_AM_EA_POP) ||
           (m == lsa_pkg::LSA_AM_FD_PUSH);
  endfunction : is_dec

  function automatic logic [31:0] extend(input logic [31:0] v, input lsa_pkg::lsa_size_t sz,
                                         input logic sgn);
    logic [31:0] r;
    case (sz)
      lsa_pkg::LSA_SZ_BYTE: r = sgn ? {{24{v[7]}}, v[7:0]} : {24'h000000, v[7:0]};
      lsa_pkg::LSA_SZ_HALF: r = sgn ? {{16{v[15]}}, v[15:0]} : {16'h0000, v[15:0]};
      default: r = v;
    endcase
    return r;
  endfunction : extend

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic [31:0] pc_base;
  logic [31:0] pc_ofs;
  logic [31:0] n4;
  logic [3:0] nxt;
  logic [15:0] rem;
  logic [31:0] ld_val;

  always_comb begin
    s_d = s_q;
    s_d.wr.valid = 1'b0;
    s_d.br_v = 1'b0;
    s_d.done = 1'b0;
    pc_base = {pc_val[31:2], 2'h0};
    pc_ofs = {19'h00000, instr.pcrel_ofs};
    n4 = {25'h0000000, s_q.count, 2'h0};
    nxt = 4'h0;
    rem = s_q.left;
    ld_val = extend(mem_rdata, s_q.req.size, s_q.ins.signed_ld);
    rem[s_q.cur] = 1'b0;
    case (s_q.st)
      LSA_ST_IDLE: begin
        s_d.unpred = 1'b0;
        if (instr_valid) begin
          s_d.ins = instr;
          s_d.base = base_val;
          s_d.second = 1'b0;
          s_d.left = instr.reg_list;
          s_d.count = pop_count(instr.reg_list);
          s_d.req = '0;
          s_d.req.size = instr.size;
          s_d.req.write = !instr.is_load;
          if (illegal) begin
            s_d.unpred = 1'b1;
            s_d.done = 1'b1;
          end else begin
            s_d.st = LSA_ST_REQ;
            s_d.req.valid = 1'b1;
            case (instr.form)
              lsa_pkg::LSA_OP_REG_OFS: begin
                s_d.addr = base_val + (offset_val << instr.shift);
                s_d.cur = instr.transfer_reg;
              end
              lsa_pkg::LSA_OP_UNPRIV: begin
                s_d.addr = base_val + {24'h000000, instr.unpriv_ofs};
                s_d.req.unpriv = 1'b1;
                s_d.cur = instr.transfer_reg;
              end
              lsa_pkg::LSA_OP_MULTI: begin
                s_d.req.size = lsa_pkg::LSA_SZ_WORD;
                if (is_dec(instr.amode)) begin
                  s_d.cur = high_reg(instr.reg_list);
                  s_d.addr = base_val - lsa_pkg::LSA_WORD_STEP;
                end else begin
                  s_d.cur = low_reg(instr.reg_list);
                  s_d.addr = base_val;
                end
              end
              default: begin
                s_d.cur = instr.transfer_reg;
                if (instr.form == lsa_pkg::LSA_OP_PCREL_DUAL) begin
                  s_d.req.size = lsa_pkg::LSA_SZ_WORD;
                end
                s_d.addr = instr.pcrel_neg ? pc_base - pc_ofs : pc_base + pc_ofs;
              end
            endcase
          end
        end
      end
      LSA_ST_REQ: begin
        if (mem_ready) begin
          s_d.req.valid = 1'b0;
          s_d.st = s_q.ins.is_load ? LSA_ST_WAIT : LSA_ST_WB;
        end
      end
      LSA_ST_WAIT: begin
        if (mem_rvalid) begin
          s_d.st = LSA_ST_WB;
          s_d.wr.valid = 1'b1;
          s_d.wr.reg_idx = s_q.cur;
          s_d.wr.value = ld_val;
          if (s_q.cur == lsa_pkg::LSA_REG_PC) begin
            s_d.wr.valid = 1'b0;
            s_d.br_v = 1'b1;
            s_d.br_t = mem_rdata & lsa_pkg::LSA_PC_BIT0_CLEAR;
          end
        end
      end
      LSA_ST_WB: begin
        s_d.st = LSA_ST_IDLE;
        if (s_q.ins.form == lsa_pkg::LSA_OP_MULTI && rem != 16'h0000) begin
          s_d.st = LSA_ST_REQ;
          s_d.left = rem;
          s_d.req.valid = 1'b1;
          if (is_dec(s_q.ins.amode)) begin
            nxt = high_reg(rem);
            s_d.addr = s_q.addr - lsa_pkg::LSA_WORD_STEP;
          end else begin
            nxt = low_reg(rem);
            s_d.addr = s_q.addr + lsa_pkg::LSA_WORD_STEP;
          end
          s_d.cur = nxt;
        end else if (s_q.ins.form == lsa_pkg::LSA_OP_PCREL_DUAL && !s_q.second) begin
          s_d.st = LSA_ST_REQ;
          s_d.second = 1'b1;
          s_d.req.valid = 1'b1;
          s_d.cur = s_q.ins.second_transfer_reg;
          s_d.addr = s_q.addr + lsa_pkg::LSA_WORD_STEP;
        end else begin
          s_d.done = 1'b1;
          // offset forms never write the base back
          if (s_q.ins.form == lsa_pkg::LSA_OP_MULTI && s_q.ins.writeback) begin
            s_d.wr.valid = 1'b1;
            s_d.wr.reg_idx = s_q.ins.base_reg;
            if (is_dec(s_q.ins.amode)) begin
              s_d.wr.value = s_q.base - n4;
            end else begin
              s_d.wr.value = s_q.base + n4 - lsa_pkg::LSA_WORD_STEP;
            end
          end
        end
      end
      default: s_d.st = LSA_ST_IDLE;
    endcase
    if (s_d.req.valid && s_d.req.write) begin
      s_d.req.wdata = rd_val;
    end
    s_d.req.addr = s_d.addr;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // store data is read from the register file for the register about to issue
  assign rd_idx = (s_q.st == LSA_ST_IDLE && instr.form == lsa_pkg::LSA_OP_MULTI) ?
                  (is_dec(instr.amode) ? high_reg(instr.reg_list) : low_reg(instr.reg_list)) :
                  (s_q.st == LSA_ST_IDLE) ? instr.transfer_reg :
                  (s_q.st == LSA_ST_WB && s_q.ins.form == lsa_pkg::LSA_OP_MULTI) ?
                  (is_dec(s_q.ins.amode) ? high_reg(rem) : low_reg(rem)) : s_q.cur;
  assign instr_ready = s_q.st == LSA_ST_IDLE;
  assign mem_req = s_q.req;
  assign reg_wr = s_q.wr;
  assign branch_valid = s_q.br_v;
  assign branch_target = s_q.br_t;
  assign flags_we = 1'b0;
  assign unpredictable = s_q.unpred;
  assign done = s_q.done;

endmodule : lsa_unit

`default_nettype wire

// [dv/lsa_unit_asserts.sv]
`default_nettype none

module lsa_unit_asserts (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic instr_valid,
  input wire logic instr_ready,
  input wire lsa_pkg::lsa_instr_t instr,
  input wire logic [31:0] base_val,
  input wire logic [31:0] offset_val,
  input wire lsa_pkg::lsa_mem_req_t mem_req,
  input wire lsa_pkg::lsa_reg_wr_t reg_wr,
  input wire logic branch_valid,
  input wire logic [31:0] branch_target,
  input wire logic flags_we,
  input wire logic unpredictable,
  input wire logic done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic tk;
  logic multi_q;
  assign tk = instr_valid && instr_ready;
  // ------------------------------------------------------------
  // form of the instruction in flight
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      multi_q <= 1'b0;
    end else if (tk) begin
      multi_q <= instr.form == lsa_pkg::LSA_OP_MULTI;
    end
  end
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  flags_quiet_a: assert property (!flags_we)
    else $error("flags write seen");
  pc_base_a: assert property (tk && instr.form == lsa_pkg::LSA_OP_REG_OFS
    && instr.base_reg == lsa_pkg::LSA_REG_PC |=> done && unpredictable)
    else $error("pc base not rejected");
  unpriv_sp_a: assert property (tk && instr.form == lsa_pkg::LSA_OP_UNPRIV
    && instr.transfer_reg == lsa_pkg::LSA_REG_SP |=> done && unpredictable)
    else $error("sp transfer not rejected");
  list_empty_a: assert property (tk && instr.form == lsa_pkg::LSA_OP_MULTI
    && instr.reg_list == 16'h0000 |=> unpredictable)
    else $error("empty list not rejected");
  list_sp_a: assert property (tk && instr.form == lsa_pkg::LSA_OP_MULTI
    && instr.reg_list[13] |=> unpredictable)
    else $error("sp in list not rejected");
  cond_pc_a: assert property (tk && instr.form == lsa_pkg::LSA_OP_PCREL && instr.is_load
    && instr.size == lsa_pkg::LSA_SZ_WORD && instr.transfer_reg == lsa_pkg::LSA_REG_PC
    && instr.cond && !instr.last_in_block |=> unpredictable)
    else $error("conditional pc load not rejected");
  reject_quiet_a: assert property (unpredictable |-> !mem_req.valid && !reg_wr.valid
    && !branch_valid)
    else $error("side effect after reject");
  ofs_addr_a: assert property (tk && instr.form == lsa_pkg::LSA_OP_REG_OFS
    |=> !mem_req.valid
    || mem_req.addr == $past(base_val) + ($past(offset_val) << $past(instr.shift)))
    else $error("register offset address wrong");
  unpriv_addr_a: assert property (tk && instr.form == lsa_pkg::LSA_OP_UNPRIV
    |=> !mem_req.valid || (mem_req.unpriv
    && mem_req.addr == $past(base_val) + {24'h000000, $past(instr.unpriv_ofs)}))
    else $error("unprivileged access wrong");
  multi_word_a: assert property (multi_q && mem_req.valid |->
    mem_req.size == lsa_pkg::LSA_SZ_WORD)
    else $error("multiple transfer not word");
  branch_even_a: assert property (branch_valid |-> !branch_target[0])
    else $error("branch target odd");
endmodule : lsa_unit_asserts

bind lsa_unit lsa_unit_asserts u_lsa_chk (.clk_sys, .reset_n, .instr_valid, .instr_ready,
  .instr, .base_val, .offset_val, .mem_req, .reg_wr, .branch_valid, .branch_target,
  .flags_we, .unpredictable, .done);

`default_nettype wire

// [dv/lsa_mem_model.sv]
`default_nettype none

module lsa_mem_model #(
  parameter logic [31:0] KEY = 32'h8F0F_80F1
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [1:0] stall,
  input wire lsa_pkg::lsa_mem_req_t mem_req,
  output logic mem_ready,
  output logic mem_rvalid,
  output logic [31:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] wait_q;
  // read data is a keyed image of the address; idle cycles invert the previous value
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mem_ready <= 1'b0;
      mem_rvalid <= 1'b0;
      mem_rdata <= 32'h0000_0000;
      wait_q <= 2'h0;
    end else begin
      mem_ready <= 1'b0;
      mem_rvalid <= mem_req.valid && mem_ready && !mem_req.write;
      mem_rdata <= (mem_req.valid && mem_ready) ? mem_req.addr ^ KEY : ~mem_rdata;
      if (mem_req.valid && !mem_ready) begin
        mem_ready <= wait_q == stall;
        wait_q <= (wait_q == stall) ? 2'h0 : wait_q + 2'h1;
      end
    end
  end
endmodule : lsa_mem_model

`default_nettype wire

// [dv/test_load_store_address_unit.sv]
`default_nettype none

module test_load_store_address_unit;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] KEY = 32'h8F0F_80F1;
  localparam logic [31:0] BASE = 32'h2000_0104;
  // form, load, size, signed, base, transfer of each rejected case
  localparam logic [23:0] ILL [17] = '{24'h4120F1, 24'h412041, 24'h402041, 24'h412041,
    24'h412041, 24'h412041, 24'h0120F1, 24'h00004D, 24'h00204F, 24'h012041, 24'h21204F,
    24'h11204D, 24'h312041, 24'h312041, 24'h002141, 24'h210041, 24'h312041};
  localparam logic [15:0] LISTS [6] = '{16'h0205, 16'h2001, 16'h8001, 16'hC000, 16'h0011, 16'h0};
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic instr_valid = 1'b0;
  lsa_pkg::lsa_instr_t instr = '0;
  logic [31:0] base_val = 32'h0000_0000;
  logic [31:0] offset_val = 32'h0000_0000;
  logic [31:0] pc_val = 32'h0000_8002;
  logic [1:0] stall = 2'h0;
  logic instr_ready, mem_ready, mem_rvalid, branch_valid, flags_we, unpredictable, done;
  logic [3:0] rd_idx;
  logic [31:0] rd_val, mem_rdata, branch_target;
  lsa_pkg::lsa_mem_req_t mem_req;
  lsa_pkg::lsa_reg_wr_t reg_wr;
  int error_cnt = 0;
  int checked = 0;
  int cycles = 0;
  logic [31:0] aq[$];
  logic [32:0] wq[$];
  logic [35:0] rq[$];
  logic [31:0] bq[$];
  logic fin, unp;
  assign rd_val = {28'hC0DE5A0, rd_idx};
  always #50 clk_sys = ~clk_sys;
  lsa_unit DUT (.clk_sys, .reset_n, .instr_valid, .instr_ready, .instr, .base_val, .offset_val,
    .pc_val, .rd_idx, .rd_val, .mem_req, .mem_ready, .mem_rvalid, .mem_rdata, .reg_wr,
    .branch_valid, .branch_target, .flags_we, .unpredictable, .done);
  lsa_mem_model #(.KEY(KEY)) u_mem (.clk_sys, .reset_n, .stall, .mem_req, .mem_ready,
    .mem_rvalid, .mem_rdata);
  // ------------------------------------------------------------
  // monitor and verdict
  // ------------------------------------------------------------
  always @(posedge clk_sys) begin
    cycles++;
    if (mem_req.valid && mem_ready) begin
      aq.push_back(mem_req.addr);
      wq.push_back({mem_req.unpriv, mem_req.wdata});
    end
    if (reg_wr.valid) rq.push_back({reg_wr.reg_idx, reg_wr.value});
    if (branch_valid) bq.push_back(branch_target);
    if (done) begin
      fin = 1'b1;
      unp = unpredictable;
    end
    if (cycles == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input string what, input logic [35:0] seen, input logic [35:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  function automatic lsa_pkg::lsa_instr_t mk(input lsa_pkg::lsa_form_t f, input logic ld,
      input lsa_pkg::lsa_size_t sz, input logic sg, input logic [3:0] bn, input logic [3:0] tr);
    mk = '0;
    mk.form = f;
    mk.is_load = ld;
    mk.size = sz;
    mk.signed_ld = sg;
    mk.base_reg = bn;
    mk.offset_reg = 4'h2;
    mk.transfer_reg = tr;
    mk.second_transfer_reg = 4'h5;
    mk.reg_list = 16'h0205;
    mk.privileged = 1'b1;
  endfunction : mk
  // one instruction, offered at one edge, collected until done
  task automatic run(input lsa_pkg::lsa_instr_t i, input logic [31:0] o);
    aq.delete();
    wq.delete();
    rq.delete();
    bq.delete();
    fin = 1'b0;
    unp = 1'bx;
    instr = i;
    base_val = BASE;
    offset_val = o;
    instr_valid = 1'b1;
    @(posedge clk_sys);
    #5 instr_valid = 1'b0;
    for (int n = 0; n < 300 && !fin; n++) begin
      @(posedge clk_sys);
      #5;
    end
    if (!fin) begin
      error_cnt++;
    end
  endtask : run
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic s_single();
    lsa_pkg::lsa_instr_t i;
    logic [31:0] d;
    for (int s = 0; s < 4; s++) begin
      i = mk(lsa_pkg::LSA_OP_REG_OFS, 1'b1, lsa_pkg::LSA_SZ_WORD, 1'b0, 4'h4, 4'h1);
      i.shift = 2'(s);
      run(i, 32'h0000_0013);
      d = BASE + (32'h0000_0013 << s);
      chk("ofs addr", aq[0], d);
      chk("ofs load", rq[0], {4'h1, d ^ KEY});
      chk("ofs writes", rq.size(), 1);
    end
    for (int k = 0; k < 4; k++) begin
      i = mk(lsa_pkg::LSA_OP_REG_OFS, 1'b1, lsa_pkg::lsa_size_t'(k / 2), !k[0], 4'h4, 4'h1);
      run(i, 32'h0);
      d = BASE ^ KEY;
      d = k < 2 ? {{24{~k[0] & d[7]}}, d[7:0]} : {{16{~k[0] & d[15]}}, d[15:0]};
      chk("extend", rq[0], {4'h1, d});
    end
    i = mk(lsa_pkg::LSA_OP_REG_OFS, 1'b0, lsa_pkg::LSA_SZ_WORD, 1'b0, 4'h4, 4'h6);
    run(i, 32'h0);
    chk("store data", wq[0], {5'h0C, 28'h0DE5A06});
    for (int k = 0; k < 2; k++) begin
      i = mk(lsa_pkg::LSA_OP_UNPRIV, 1'b0, lsa_pkg::LSA_SZ_WORD, 1'b0, 4'h4, 4'h3);
      i.unpriv_ofs = k ? 8'hFF : 8'h00;
      run(i, 32'h0);
      chk("unpriv addr", aq[0], BASE + (k ? 32'h0000_00FF : 32'h0));
      chk("unpriv flag", wq[0][32], 1'b1);
    end
  endtask : s_single
  task automatic s_pcrel();
    lsa_pkg::lsa_instr_t i;
    logic [31:0] a;
    for (int k = 0; k < 2; k++) begin
      i = mk(lsa_pkg::LSA_OP_PCREL, 1'b1, lsa_pkg::LSA_SZ_BYTE, 1'b0, 4'h4, 4'h1);
      i.pcrel_ofs = 13'h0FFF;
      i.pcrel_neg = k[0];
      run(i, 32'h0);
      a = k ? 32'h0000_7001 : 32'h0000_8FFF;
      chk("pcrel addr", aq[0], a);
      chk("pcrel zext", rq[0], {28'h1000000, a[7:0] ^ KEY[7:0]});
    end
    i = mk(lsa_pkg::LSA_OP_PCREL_DUAL, 1'b1, lsa_pkg::LSA_SZ_WORD, 1'b0, 4'h4, 4'h1);
    i.pcrel_ofs = 13'h03FC;
    run(i, 32'h0);
    chk("dual first", rq[0], {4'h1, 32'h0000_83FC ^ KEY});
    chk("dual second", rq[1], {4'h5, 32'h0000_8400 ^ KEY});
    i = mk(lsa_pkg::LSA_OP_PCREL, 1'b1, lsa_pkg::LSA_SZ_WORD, 1'b0, 4'h4, 4'hF);
    i.cond = 1'b1;
    i.last_in_block = 1'b1;
    run(i, 32'h0);
    chk("branch", bq[0], (32'h0000_8000 ^ KEY) & 32'hFFFF_FFFE);
    chk("branch writes", rq.size(), 0);
    chk("flags", flags_we, 1'b0);
  endtask : s_pcrel
  task automatic s_multi();
    lsa_pkg::lsa_instr_t i;
    logic [31:0] a;
    logic [3:0] r;
    logic inc;
    int j;
    stall = 2'h2;
    for (int m = 0; m < 6; m++) begin
      inc = m == 0 || m == 2 || m == 3;
      i = mk(lsa_pkg::LSA_OP_MULTI, m != 3 && m != 5, lsa_pkg::LSA_SZ_WORD, 1'b0, 4'h4, 4'h0);
      i.amode = lsa_pkg::lsa_amode_t'(m);
      i.writeback = 1'b1;
      run(i, 32'h0);
      for (int n = 0; n < 3; n++) begin
        j = inc ? n : 2 - n;
        r = j == 0 ? 4'h0 : (j == 1 ? 4'h2 : 4'h9);
        a = BASE + 32'(4 * j) - (inc ? 32'h0 : 32'hC);
        chk("multi addr", aq[n], a);
        if (i.is_load) chk("multi load", rq[n], {r, a ^ KEY});
        else chk("multi store", wq[n], {5'h0C, 24'h0DE5A0, r});
      end
      a = inc ? BASE + 32'h8 : BASE - 32'hC;
      chk("multi wb", rq[i.is_load ? 3 : 0], {4'h4, a});
    end
    stall = 2'h0;
  endtask : s_multi
  task automatic s_illegal();
    lsa_pkg::lsa_instr_t i;
    logic [23:0] c;
    for (int k = 0; k < 17; k++) begin
      c = ILL[k];
      i = mk(lsa_pkg::lsa_form_t'(c[22:20]), c[16], lsa_pkg::lsa_size_t'(c[13:12]), c[8],
        c[7:4], c[3:0]);
      if (k < 6) i.reg_list = LISTS[k];
      i.writeback = k == 4;
      i.offset_reg = k == 9 ? 4'hD : 4'h2;
      i.cond = k == 10;
      i.second_transfer_reg = k == 12 ? 4'hF : (k == 13 ? 4'h1 : 4'h5);
      i.pcrel_ofs = k == 15 ? 13'h1000 : (k == 16 ? 13'h0400 : 13'h0000);
      run(i, 32'h0);
      chk("reject", unp, 1'b1);
      chk("reject quiet", aq.size() + rq.size() + bq.size(), 0);
      chk("idle again", instr_ready, 1'b1);
    end
  endtask : s_illegal
  initial begin
    repeat (16) @(posedge clk_sys);
    #5 reset_n = 1'b1;
    s_single();
    s_pcrel();
    s_multi();
    s_illegal();
    give_verdict();
  end
endmodule : test_load_store_address_unit

`default_nettype wire
